/* File: hw/fpot_pkg.sv */
package fpot_pkg;

  // Clock and output timing
  localparam int unsigned CLK_HZ     = 10_000_000;
  localparam int unsigned FMAX_LO_HZ = 1000;
  localparam int unsigned FMAX_HI_HZ = 5000;
  localparam int unsigned QSTEPS     = 4;
  localparam int unsigned SEC_PER_MIN = 60;
  localparam int unsigned TICK_S      = 1;
  localparam int unsigned TICK_CYCLES = TICK_S * CLK_HZ;
  // Phase increments for 100 % at each maximum frequency (32-bit accumulator)
  localparam logic [31:0] INC_LO = 32'((64'(QSTEPS * FMAX_LO_HZ) << 32) / 64'(CLK_HZ));
  localparam logic [31:0] INC_HI = 32'((64'(QSTEPS * FMAX_HI_HZ) << 32) / 64'(CLK_HZ));

  // Test timeout, minutes
  localparam logic [4:0]  TMO_MIN_LO  = 5'h01;
  localparam logic [4:0]  TMO_MIN_HI  = 5'h1e;
  localparam logic [4:0]  TMO_MIN_DEF = 5'h02;

  // Percent and fraction scaling (Q16, 100 % = 1.0)
  localparam logic [7:0]  PCT_MAX   = 8'h96;
  localparam logic [7:0]  PCT_FULL  = 8'h64;
  localparam int unsigned FRAC_W    = 16;
  localparam logic [16:0] FRAC_CLIP = 17'h1_8000;

  // Test channels
  localparam int unsigned NCH    = 6;
  localparam int unsigned NFO    = 2;
  localparam int unsigned NDO    = 4;
  localparam int unsigned CH_CUR = 2;
  localparam int unsigned CH_DO  = 4;

  // Register byte offsets
  localparam logic [7:0] REG_FO_CFG0  = 8'h00;
  localparam logic [7:0] REG_FO_CFG1  = 8'h04;
  localparam logic [7:0] REG_FSCALE0  = 8'h08;
  localparam logic [7:0] REG_FSCALE1  = 8'h0c;
  localparam logic [7:0] REG_VMAX0    = 8'h10;
  localparam logic [7:0] REG_VMAX1    = 8'h14;
  localparam logic [7:0] REG_VMIN0    = 8'h18;
  localparam logic [7:0] REG_VMIN1    = 8'h1c;
  localparam logic [7:0] REG_KFAC0    = 8'h20;
  localparam logic [7:0] REG_KFAC1    = 8'h24;
  localparam logic [7:0] REG_VPP0     = 8'h28;
  localparam logic [7:0] REG_VPP1     = 8'h2c;
  localparam logic [7:0] REG_TEST_PCT = 8'h30;
  localparam logic [7:0] REG_DO_CFG   = 8'h34;
  localparam logic [7:0] REG_TEST_CMD = 8'h38;
  localparam logic [7:0] REG_TMO      = 8'h3c;

  // Field positions in TEST_CMD and DO_CFG
  localparam int unsigned CMD_START_LSB = 0;
  localparam int unsigned CMD_STOP_LSB  = 8;
  localparam int unsigned CMD_REFR_LSB  = 16;
  localparam int unsigned DO_SEL_LSB    = 0;
  localparam int unsigned DO_INV_LSB    = 4;
  localparam int unsigned DO_TEST_LSB   = 8;

  typedef enum logic [1:0] {
    DIR_REV  = 2'b00,
    DIR_FWD  = 2'b01,
    DIR_ABS  = 2'b10,
    DIR_BIDI = 2'b11
  } fpot_dir_e;

  typedef enum logic [1:0] {
    TST_IDLE = 2'b00,
    TST_PEND = 2'b01,
    TST_ON   = 2'b10,
    TST_STOP = 2'b11
  } fpot_tst_e;

  // Frequency output configuration word, bit 0 first from the right
  typedef struct packed {
    logic      b_zero_err;
    logic      lead_fwd;
    logic      fmax_hi;
    fpot_dir_e dir;
    logic      vel;
  } fpot_fo_cfg_s;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } fpot_bus_s;

  typedef struct packed {
    logic signed [31:0] flow;
    logic signed [31:0] vel;
    logic               valid;
    logic               batch_end;
  } fpot_meas_s;

  typedef struct packed {
    logic [NFO-1:0]      fo_a;
    logic [NFO-1:0]      fo_b;
    logic [NDO-1:0]      do_lvl;
    logic [1:0]          cur_force;
    logic [1:0][7:0]     cur_pct;
  } fpot_pins_s;

endpackage

/* File: hw/fpot_top.sv */
// Overview of operation
// - Reverse mode: pulses only for reverse flow, B a quarter cycle from A.
// - Forward mode: pulses only for forward flow, B a quarter cycle from A.
// - Absolute mode: pulses for either direction, B a quarter cycle from A.
// - Bidirectional mode: forward pulses on A only, reverse pulses on B only.
// - Maximum frequency per output selectable as 1 kHz or 5 kHz.
// - Volumetric content: full-scale flow maps to the selected maximum frequency.
// - Read-only pulses-per-volume factor from full scale and maximum frequency.
// - Read-only volume-per-pulse equals reciprocal of that factor.
// - Velocity content: max velocity to max frequency, min velocity to 0 Hz, linear.
// - Test mode drives each frequency or current output at 0 to 150 percent.
// - Each frequency or current output, and each pair of digital outputs, enters test mode by its own start command.
// - Forced frequency and current values take effect at the next batch end.
// - With B zero-on-error set, B phase holds at zero under test.
// - Test mode forces each digital output high or low as commanded.
// - Host refreshes test values; each refresh restarts that output's timeout.
// - Unrefreshed test ends after 1 to 30 minute timeout, default two.
// - Test percentage is writable only while that output is out of test.
// - Stop returns live values at batch end, or at once for digital outputs, then reports test inactive.
// - Phase option: B lags forward and leads reverse, or the opposite.
// - Inversion option makes a true digital condition drive low.
//
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module fpot_top #(
  parameter int unsigned SEC_CYCLES = fpot_pkg::TICK_CYCLES
) (
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire fpot_pkg::fpot_bus_s  bus,
  input  wire fpot_pkg::fpot_meas_s meas,
  output logic [31:0]               rdata,
  output fpot_pkg::fpot_pins_s      pins
);

  typedef struct packed {
    fpot_pkg::fpot_fo_cfg_s [1:0] fo_cfg;
    logic [1:0][31:0]             fscale;
    logic [1:0][31:0]             vmax;
    logic [1:0][31:0]             vmin;
    logic [3:0][7:0]              pct;
    logic [3:0]                   do_sel;
    logic [3:0]                   do_inv;
    logic [3:0]                   do_test;
    logic [4:0]                   tmo_min;
    fpot_pkg::fpot_tst_e [5:0]    tst;
    logic [5:0][10:0]             tmo_sec;
    logic [31:0]                  sec_cnt;
    logic [1:0][31:0]             inc;
    logic [1:0][31:0]             acc;
    logic [1:0][1:0]              step;
    logic [1:0]                   rev;
    logic [1:0]                   b_off;
    fpot_pkg::fpot_pins_s         pins;
    logic [31:0]                  rdata;
  } fpot_state_s;

  fpot_state_s s_r;
  fpot_state_s s_nxt;

  // Quotient in Q16; a zero divisor yields zero, overflow saturates
  function automatic logic [31:0] div_q16(input logic [31:0] num, input logic [31:0] den);
    logic [63:0] q;
    q = 64'h0000_0000_0000_0000;
    if (den != 32'h0000_0000)
    begin
      q = {16'h0000, num, 16'h0000} / {32'h0000_0000, den};
    end
    if (q[63:32] != 32'h0000_0000)
    begin
      q = {32'h0000_0000, 32'hffff_ffff};
    end
    return q[31:0];
  endfunction

  function automatic logic [31:0] fmax_hz(input fpot_pkg::fpot_fo_cfg_s c);
    return c.fmax_hi ? 32'(fpot_pkg::FMAX_HI_HZ) : 32'(fpot_pkg::FMAX_LO_HZ);
  endfunction

  function automatic logic [16:0] clip_frac(input logic [31:0] f);
    return (f > {15'h0000, fpot_pkg::FRAC_CLIP}) ? fpot_pkg::FRAC_CLIP : f[16:0];
  endfunction

  function automatic logic under_test(input fpot_pkg::fpot_tst_e t);
    return (t == fpot_pkg::TST_ON) || (t == fpot_pkg::TST_STOP);
  endfunction

  function automatic logic armed(input fpot_pkg::fpot_tst_e t);
    return (t == fpot_pkg::TST_PEND) || (t == fpot_pkg::TST_ON);
  endfunction

  logic              sec_tick;
  logic [31:0]       mag;
  logic              neg;
  logic [31:0]       frac_w;
  logic [16:0]       frac;
  logic              fwd_pass;
  logic              rev_pass;
  logic              testing;
  logic [63:0]       prod;
  logic [32:0]       sum;
  logic [1:0]        gray;
  logic              b_leads;
  logic              cond;
  logic [10:0]       limit;
  logic [31:0]       span;
  logic              expire;
  logic [1:0]        fo_ix;

  always_comb
  begin
    s_nxt    = s_r;
    mag      = meas.flow[31] ? 32'(-meas.flow) : meas.flow;
    neg      = meas.flow[31];
    frac_w   = 32'h0000_0000;
    frac     = 17'h0_0000;
    fwd_pass = 1'b0;
    rev_pass = 1'b0;
    testing  = 1'b0;
    prod     = 64'h0000_0000_0000_0000;
    sum      = 33'h0_0000_0000;
    gray     = 2'b00;
    b_leads  = 1'b0;
    cond     = 1'b0;
    span     = 32'h0000_0000;
    expire   = 1'b0;
    fo_ix    = 2'b00;
    limit    = 11'(s_r.tmo_min) * 11'(fpot_pkg::SEC_PER_MIN);

    // One-second enable for the test timeouts
    sec_tick = (s_r.sec_cnt >= SEC_CYCLES - 1);
    s_nxt.sec_cnt = sec_tick ? 32'h0000_0000 : s_r.sec_cnt + 32'h0000_0001;

    // Batch boundary: pending starts apply, pending stops release
    if (meas.batch_end)
    begin
      for (int ch = 0; ch < fpot_pkg::CH_DO; ch++)
      begin
        case (s_r.tst[ch])
          fpot_pkg::TST_PEND: s_nxt.tst[ch] = fpot_pkg::TST_ON;
          fpot_pkg::TST_STOP: s_nxt.tst[ch] = fpot_pkg::TST_IDLE;
          default:            s_nxt.tst[ch] = s_r.tst[ch];
        endcase
      end
    end

    // Timeouts count whole seconds while a test is armed
    for (int ch = 0; ch < fpot_pkg::NCH; ch++)
    begin
      if (armed(s_nxt.tst[ch]) && sec_tick)
      begin
        s_nxt.tmo_sec[ch] = s_r.tmo_sec[ch] + 11'h001;
        expire = (s_nxt.tmo_sec[ch] >= limit);
        if (expire)
        begin
          // Digital outputs have no batch to wait for
          s_nxt.tst[ch] = (ch >= fpot_pkg::CH_DO) ? fpot_pkg::TST_IDLE
                                                 : fpot_pkg::TST_STOP;
        end
      end
    end

    // Register writes
    if (bus.wr)
    begin
      if (bus.addr == fpot_pkg::REG_FO_CFG0 || bus.addr == fpot_pkg::REG_FO_CFG1)
      begin
        s_nxt.fo_cfg[bus.addr == fpot_pkg::REG_FO_CFG1] = bus.wdata[5:0];
      end
      else if (bus.addr == fpot_pkg::REG_FSCALE0 || bus.addr == fpot_pkg::REG_FSCALE1)
      begin
        s_nxt.fscale[bus.addr == fpot_pkg::REG_FSCALE1] = bus.wdata;
      end
      else if (bus.addr == fpot_pkg::REG_VMAX0 || bus.addr == fpot_pkg::REG_VMAX1)
      begin
        s_nxt.vmax[bus.addr == fpot_pkg::REG_VMAX1] = bus.wdata;
      end
      else if (bus.addr == fpot_pkg::REG_VMIN0 || bus.addr == fpot_pkg::REG_VMIN1)
      begin
        s_nxt.vmin[bus.addr == fpot_pkg::REG_VMIN1] = bus.wdata;
      end
      else if (bus.addr == fpot_pkg::REG_TEST_PCT)
      begin
        for (int i = 0; i < 4; i++)
        begin
          // Ignored per byte while the channel is anywhere in test
          if (s_r.tst[i] == fpot_pkg::TST_IDLE && bus.wdata[8*i +: 8] <= fpot_pkg::PCT_MAX)
          begin
            s_nxt.pct[i] = bus.wdata[8*i +: 8];
          end
        end
      end
      else if (bus.addr == fpot_pkg::REG_DO_CFG)
      begin
        s_nxt.do_sel  = bus.wdata[fpot_pkg::DO_SEL_LSB +: 4];
        s_nxt.do_inv  = bus.wdata[fpot_pkg::DO_INV_LSB +: 4];
        s_nxt.do_test = bus.wdata[fpot_pkg::DO_TEST_LSB +: 4];
      end
      else if (bus.addr == fpot_pkg::REG_TEST_CMD)
      begin
        for (int ch = 0; ch < fpot_pkg::NCH; ch++)
        begin
          if (bus.wdata[fpot_pkg::CMD_START_LSB + ch] && s_nxt.tst[ch] == fpot_pkg::TST_IDLE)
          begin
            s_nxt.tst[ch] = (ch >= fpot_pkg::CH_DO) ? fpot_pkg::TST_ON
                                                   : fpot_pkg::TST_PEND;
            s_nxt.tmo_sec[ch] = 11'h000;
          end
          else if (bus.wdata[fpot_pkg::CMD_STOP_LSB + ch] && armed(s_nxt.tst[ch]))
          begin
            s_nxt.tst[ch] = (ch >= fpot_pkg::CH_DO) ? fpot_pkg::TST_IDLE
                                                   : fpot_pkg::TST_STOP;
          end
          else if (bus.wdata[fpot_pkg::CMD_REFR_LSB + ch] && armed(s_nxt.tst[ch]))
          begin
            s_nxt.tmo_sec[ch] = 11'h000;
          end
        end
      end
      else if (bus.addr == fpot_pkg::REG_TMO)
      begin
        if (bus.wdata[4:0] < fpot_pkg::TMO_MIN_LO || bus.wdata[31:5] != 27'h000_0000)
        begin
          s_nxt.tmo_min = (bus.wdata[4:0] < fpot_pkg::TMO_MIN_LO && bus.wdata[31:5] == 27'h0)
                          ? fpot_pkg::TMO_MIN_LO : fpot_pkg::TMO_MIN_HI;
        end
        else
        begin
          s_nxt.tmo_min = (bus.wdata[4:0] > fpot_pkg::TMO_MIN_HI) ? fpot_pkg::TMO_MIN_HI
                                                               : bus.wdata[4:0];
        end
      end
    end

    // New frequency targets are latched only on a batch boundary
    if (meas.batch_end)
    begin
      for (int f = 0; f < fpot_pkg::NFO; f++)
      begin
        testing = under_test(s_nxt.tst[f]);
        if (testing)
        begin
          frac_w   = div_q16({24'h00_0000, s_r.pct[f]}, {24'h00_0000, fpot_pkg::PCT_FULL});
          fwd_pass = 1'b1;
          rev_pass = 1'b0;
        end
        else if (s_r.fo_cfg[f].vel)
        begin
          span = s_r.vmax[f] - s_r.vmin[f];
          if ($signed(meas.vel) > $signed(s_r.vmin[f]) && !span[31])
          begin
            frac_w = div_q16(meas.vel - s_r.vmin[f], span);
          end
          fwd_pass = !neg;
          rev_pass = neg;
        end
        else
        begin
          frac_w   = div_q16(mag, s_r.fscale[f]);
          fwd_pass = !neg;
          rev_pass = neg;
        end
        frac = clip_frac(frac_w);
        case (s_r.fo_cfg[f].dir)
          fpot_pkg::DIR_REV:  frac = (rev_pass || testing) ? frac : 17'h0_0000;
          fpot_pkg::DIR_FWD:  frac = fwd_pass ? frac : 17'h0_0000;
          fpot_pkg::DIR_ABS:  frac = frac;
          default:            frac = frac;
        endcase
        prod = {47'h0, frac} * {32'h0000_0000,
               (s_r.fo_cfg[f].fmax_hi ? fpot_pkg::INC_HI : fpot_pkg::INC_LO)};
        s_nxt.inc[f]   = prod[fpot_pkg::FRAC_W +: 32];
        s_nxt.rev[f]   = rev_pass;
        s_nxt.b_off[f] = testing && s_r.fo_cfg[f].b_zero_err;
      end
    end

    // Pulse generation: one accumulator carry per quarter cycle
    for (int f = 0; f < fpot_pkg::NFO; f++)
    begin
      sum = {1'b0, s_r.acc[f]} + {1'b0, s_r.inc[f]};
      s_nxt.acc[f] = sum[31:0];
      if (sum[32])
      begin
        s_nxt.step[f] = s_r.step[f] + 2'b01;
      end
      gray    = {s_r.step[f][1], s_r.step[f][1] ^ s_r.step[f][0]};
      b_leads = s_r.fo_cfg[f].lead_fwd ^ s_r.rev[f];
      if (s_r.fo_cfg[f].dir == fpot_pkg::DIR_BIDI)
      begin
        s_nxt.pins.fo_a[f] = !s_r.rev[f] && s_r.step[f][1];
        s_nxt.pins.fo_b[f] = s_r.rev[f] && s_r.step[f][1] && !s_r.b_off[f];
      end
      else
      begin
        s_nxt.pins.fo_a[f] = b_leads ? gray[1] : gray[0];
        s_nxt.pins.fo_b[f] = (b_leads ? gray[0] : gray[1]) && !s_r.b_off[f];
      end
    end

    // Digital outputs: validity or direction of the paired frequency output
    for (int d = 0; d < fpot_pkg::NDO; d++)
    begin
      fo_ix = 2'(d / 2);
      cond  = s_r.do_sel[d] ? !neg
                            : (meas.valid && !under_test(s_r.tst[fo_ix]));
      if (s_r.tst[fpot_pkg::CH_DO + d / 2] == fpot_pkg::TST_ON)
      begin
        s_nxt.pins.do_lvl[d] = s_r.do_test[d];
      end
      else
      begin
        s_nxt.pins.do_lvl[d] = cond ^ s_r.do_inv[d];
      end
    end

    // Current test values go to the analog stage from the batch boundary on
    for (int c = 0; c < 2; c++)
    begin
      s_nxt.pins.cur_force[c] = under_test(s_r.tst[fpot_pkg::CH_CUR + c]);
      s_nxt.pins.cur_pct[c]   = s_r.pct[fpot_pkg::CH_CUR + c];
    end

    // Read data stands in the cycle after the strobe only
    s_nxt.rdata = 32'h0000_0000;
    if (bus.rd)
    begin
      if (bus.addr == fpot_pkg::REG_FO_CFG0 || bus.addr == fpot_pkg::REG_FO_CFG1)
      begin
        s_nxt.rdata = {26'h000_0000, s_r.fo_cfg[bus.addr == fpot_pkg::REG_FO_CFG1]};
      end
      else if (bus.addr == fpot_pkg::REG_FSCALE0 || bus.addr == fpot_pkg::REG_FSCALE1)
      begin
        s_nxt.rdata = s_r.fscale[bus.addr == fpot_pkg::REG_FSCALE1];
      end
      else if (bus.addr == fpot_pkg::REG_VMAX0 || bus.addr == fpot_pkg::REG_VMAX1)
      begin
        s_nxt.rdata = s_r.vmax[bus.addr == fpot_pkg::REG_VMAX1];
      end
      else if (bus.addr == fpot_pkg::REG_VMIN0 || bus.addr == fpot_pkg::REG_VMIN1)
      begin
        s_nxt.rdata = s_r.vmin[bus.addr == fpot_pkg::REG_VMIN1];
      end
      else if (bus.addr == fpot_pkg::REG_KFAC0 || bus.addr == fpot_pkg::REG_KFAC1)
      begin
        fo_ix       = {1'b0, bus.addr == fpot_pkg::REG_KFAC1};
        s_nxt.rdata = div_q16(fmax_hz(s_r.fo_cfg[fo_ix[0]]), s_r.fscale[fo_ix[0]]);
      end
      else if (bus.addr == fpot_pkg::REG_VPP0 || bus.addr == fpot_pkg::REG_VPP1)
      begin
        fo_ix       = {1'b0, bus.addr == fpot_pkg::REG_VPP1};
        s_nxt.rdata = div_q16(s_r.fscale[fo_ix[0]], fmax_hz(s_r.fo_cfg[fo_ix[0]]));
      end
      else if (bus.addr == fpot_pkg::REG_TEST_PCT)
      begin
        s_nxt.rdata = s_r.pct;
      end
      else if (bus.addr == fpot_pkg::REG_DO_CFG)
      begin
        s_nxt.rdata = {20'h0_0000, s_r.do_test, s_r.do_inv, s_r.do_sel};
      end
      else if (bus.addr == fpot_pkg::REG_TEST_CMD)
      begin
        for (int ch = 0; ch < fpot_pkg::NCH; ch++)
        begin
          s_nxt.rdata[ch] = under_test(s_r.tst[ch]);
          s_nxt.rdata[fpot_pkg::CMD_STOP_LSB + ch] = (s_r.tst[ch] != fpot_pkg::TST_IDLE);
        end
      end
      else if (bus.addr == fpot_pkg::REG_TMO)
      begin
        s_nxt.rdata = {27'h000_0000, s_r.tmo_min};
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      s_r         <= '0;
      s_r.tmo_min <= fpot_pkg::TMO_MIN_DEF;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign rdata = s_r.rdata;
  assign pins  = s_r.pins;

endmodule

`default_nettype wire

/* File: dv/fpot_top_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module fpot_top_sva #(
  parameter int unsigned SEC_CYCLES = 10
) (
  input wire logic                 clk,
  input wire logic                 nrst,
  input wire fpot_pkg::fpot_bus_s  bus,
  input wire fpot_pkg::fpot_meas_s meas,
  input wire logic [31:0]          rdata,
  input wire fpot_pkg::fpot_pins_s pins
);
  // Timeout length is judged by the bench; the parameter only follows the design
  logic [11:0] gap_r;
  logic [11:0] gap_nxt;
  logic        pa_r;
  logic        pb_r;
  logic        chg;
  logic [1:0]  evt_r;

  assign chg = (pins.fo_a[0] != pa_r) || (pins.fo_b[0] != pb_r);

  // Saturates so a step after reset or a reconfiguration is never judged too early
  always_comb
  begin
    gap_nxt = (gap_r == 12'hfff) ? gap_r : gap_r + 12'h001;
    if (chg)
      gap_nxt = evt_r[1] ? 12'hfff : 12'h000;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      gap_r <= 12'hfff;
      pa_r  <= 1'b0;
      pb_r  <= 1'b0;
      evt_r <= 2'b00;
    end
    else
    begin
      gap_r <= gap_nxt;
      pa_r  <= pins.fo_a[0];
      pb_r  <= pins.fo_b[0];
      evt_r <= {evt_r[0], bus.wr || meas.batch_end};
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  a_rd_quiet: assert property (!$past(bus.rd) |-> rdata == 32'h0000_0000)
    else $error("read data not zero outside a read answer");
  a_quad_gray: assert property (
    !evt_r[1] && pins.fo_a[0] != $past(pins.fo_a[0]) |-> pins.fo_b[0] == $past(pins.fo_b[0]))
    else $error("both phases stepped in one cycle");
  a_quad_gray_b: assert property (
    !evt_r[1] && $changed(pins.fo_b[0]) |-> $stable(pins.fo_a[0]))
    else $error("phase b step moved phase a");
  a_step_space: assert property (chg && !evt_r[1] |-> gap_r >= 12'h140)
    else $error("phase steps closer than the clamped rate allows");
  a_force_start: assert property (
    $rose(pins.cur_force[0]) |-> $past(meas.batch_end) || $past(meas.batch_end, 2))
    else $error("current test began away from a batch end");
  a_force_stop: assert property (
    $fell(pins.cur_force[0]) |-> $past(meas.batch_end) || $past(meas.batch_end, 2))
    else $error("current test ended away from a batch end");
  a_pct_frozen: assert property (
    pins.cur_force[0] && $past(pins.cur_force[0]) && $past(pins.cur_force[0], 2)
    |-> $stable(pins.cur_pct[0]))
    else $error("test percent moved while under test");
  a_pct_limit: assert property (
    pins.cur_pct[0] <= fpot_pkg::PCT_MAX && pins.cur_pct[1] <= fpot_pkg::PCT_MAX)
    else $error("test percent above limit");

  c_force: cover property ($rose(pins.cur_force[0]));
  c_b_step: cover property ($changed(pins.fo_b[0]));
  c_read: cover property (bus.rd ##1 rdata != 32'h0000_0000);
endmodule

bind fpot_top fpot_top_sva #(.SEC_CYCLES(SEC_CYCLES)) u_fpot_top_sva (
  .clk(clk), .nrst(nrst), .bus(bus), .meas(meas), .rdata(rdata), .pins(pins));
`default_nettype wire

/* File: dv/fpot_flow_computer.sv */
`timescale 1ns/1ps
`default_nettype none
module fpot_flow_computer (
  input  wire logic  clk,
  input  wire logic  clr,
  input  wire logic  fo_a,
  input  wire logic  fo_b,
  output logic [15:0] tog_a,
  output logic [15:0] tog_b,
  output logic        b_lead
);
  logic pa;
  logic pb;

  // Counts level changes, not rising edges, to halve the window error
  always_ff @(posedge clk)
  begin
    pa <= fo_a;
    pb <= fo_b;
    if (clr)
    begin
      tog_a  <= 16'h0000;
      tog_b  <= 16'h0000;
      b_lead <= 1'b0;
    end
    else
    begin
      if (fo_a != pa)
        tog_a <= tog_a + 16'h0001;
      if (fo_b != pb)
        tog_b <= tog_b + 16'h0001;
      if (fo_a && !pa)
        b_lead <= fo_b;
    end
  end
endmodule
`default_nettype wire

/* File: dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int unsigned SECC = 100;
  localparam int unsigned FS   = 100;
  logic                 clk;
  logic                 nrst;
  logic                 clr;
  logic                 rd_d;
  fpot_pkg::fpot_bus_s  bus;
  fpot_pkg::fpot_meas_s meas;
  logic [31:0]          rdata;
  fpot_pkg::fpot_pins_s pins;
  logic [15:0]          tog_a;
  logic [15:0]          tog_b;
  logic                 b_lead;
  logic [15:0]          lfsr;
  logic [7:0]           pct3;
  int unsigned          fm;
  logic [31:0]          exp_q[$];
  logic [31:0]          msk_q[$];
  int                   n_mismatch = 0;
  int                   comparisons = 0;

  fpot_top #(.SEC_CYCLES(SECC)) u_fpot_top (.clk(clk), .nrst(nrst), .bus(bus),
    .meas(meas), .rdata(rdata), .pins(pins));
  fpot_flow_computer u_fpot_flow_computer (.clk(clk), .clr(clr), .fo_a(pins.fo_a[0]),
    .fo_b(pins.fo_b[0]), .tog_a(tog_a), .tog_b(tog_b), .b_lead(b_lead));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Window counts land within one step of the ideal
  function automatic logic [31:0] near(input logic [15:0] c, input int e);
    return {31'h0, (int'(c) + 1 >= e) && (int'(c) <= e + 1)};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  always @(posedge clk)
  begin
    rd_d <= bus.rd;
    if (rd_d === 1'b1)
      chk("rdata", exp_q.pop_front(), rdata & msk_q.pop_front());
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    @(posedge clk);
  endtask

  task automatic batch_clr();
    meas.batch_end <= 1'b1;
    @(posedge clk);
    meas.batch_end <= 1'b0;
    clr            <= 1'b1;
    @(posedge clk);
    // Second edge of clear hides the one-off phase remap that the batch causes
    @(posedge clk);
    clr <= 1'b0;
  endtask

  task automatic fo_case(input logic [7:0] cfg, input logic [31:0] v, input int ea,
                         input int eb, input int ld);
    wr(fpot_pkg::REG_FO_CFG0, {24'h0, cfg});
    meas.flow <= v;
    meas.vel  <= v;
    batch_clr();
    cyc(4000);
    chk("phase a count", 32'h0000_0001, near(tog_a, ea));
    chk("phase b count", 32'h0000_0001, near(tog_b, eb));
    if (ld < 2)
      chk("phase b leads", {31'h0, ld[0]}, {31'h0, b_lead});
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    $display("BAD watchdog expected finish seen hang");
    wrap_up();
  end

  initial
  begin
    nrst = 1'b0;
    clr  = 1'b1;
    bus  = '0;
    meas = '0;
    lfsr = 16'h4424;
    cyc(4);
    nrst       <= 1'b1;
    clr        <= 1'b0;
    meas.valid <= 1'b1;
    rd(fpot_pkg::REG_TMO, 32'h0000_0002, 32'h0000_001f);
    lfsr = lfsr_next(lfsr);
    wr(8'hfc, {lfsr, lfsr});
    rd(8'hfc, 32'h0000_0000, 32'hffff_ffff);
    $display("test reset done");
    wr(fpot_pkg::REG_FSCALE0, 32'(FS));
    for (int i = 0; i < 2; i++)
    begin
      fm = (i == 0) ? fpot_pkg::FMAX_LO_HZ : fpot_pkg::FMAX_HI_HZ;
      wr(fpot_pkg::REG_FO_CFG0, {28'h0, i[0], 3'h0});
      rd(fpot_pkg::REG_KFAC0, 32'((fm << 16) / FS), 32'hffff_ffff);
      rd(fpot_pkg::REG_VPP0, 32'((FS << 16) / fm), 32'hffff_ffff);
    end
    $display("test scaling done");
    wr(fpot_pkg::REG_VMAX0, 32'h0000_0064);
    wr(fpot_pkg::REG_VMIN0, 32'hffff_ff9c);
    fo_case(8'h08, 32'h0000_0064, 0, 0, 2);
    fo_case(8'h08, 32'hffff_ff9c, 4, 4, 1);
    fo_case(8'h0a, 32'h0000_0064, 4, 4, 0);
    fo_case(8'h0a, 32'hffff_ff9c, 0, 0, 2);
    fo_case(8'h1c, 32'hffff_ff9c, 4, 4, 0);
    fo_case(8'h0c, 32'h0000_00c8, 6, 6, 0);
    fo_case(8'h1c, 32'h0000_0032, 2, 2, 1);
    fo_case(8'h04, 32'h0000_00c8, 1, 1, 2);
    fo_case(8'h0e, 32'h0000_0064, 4, 0, 2);
    fo_case(8'h0e, 32'hffff_ff9c, 0, 4, 2);
    fo_case(8'h0d, 32'h0000_0000, 2, 2, 2);
    fo_case(8'h0d, 32'hffff_ff9c, 0, 0, 2);
    $display("test direction done");
    meas.flow <= 32'h0000_0000;
    wr(fpot_pkg::REG_TEST_PCT, 32'h0000_0032);
    wr(fpot_pkg::REG_FO_CFG0, 32'h0000_002c);
    wr(fpot_pkg::REG_TEST_CMD, 32'h0000_0001);
    rd(fpot_pkg::REG_TEST_CMD, 32'h0000_0100, 32'h0000_0101);
    batch_clr();
    rd(fpot_pkg::REG_TEST_CMD, 32'h0000_0101, 32'h0000_0101);
    wr(fpot_pkg::REG_TEST_PCT, 32'h0000_0096);
    rd(fpot_pkg::REG_TEST_PCT, 32'h0000_0032, 32'h0000_00ff);
    cyc(3990);
    chk("test phase a count", 32'h0000_0001, near(tog_a, 2));
    chk("test phase b count", 32'h0000_0000, {16'h0, tog_b});
    wr(fpot_pkg::REG_TEST_CMD, 32'h0000_0100);
    rd(fpot_pkg::REG_TEST_CMD, 32'h0000_0101, 32'h0000_0101);
    batch_clr();
    rd(fpot_pkg::REG_TEST_CMD, 32'h0000_0000, 32'h0000_0101);
    $display("test frequency forcing done");
    lfsr = lfsr_next(lfsr);
    pct3 = 8'h97 + {2'b00, lfsr[5:0]};
    wr(fpot_pkg::REG_TEST_PCT, {pct3, 8'h96, 16'h0000});
    wr(fpot_pkg::REG_TEST_CMD, 32'h0000_0004);
    chk("current force early", 32'h0000_0000, {30'h0, pins.cur_force});
    batch_clr();
    cyc(2);
    chk("current force", 32'h0000_0001, {30'h0, pins.cur_force});
    chk("current percent", 32'h0000_0096, {24'h0, pins.cur_pct[0]});
    rd(fpot_pkg::REG_TEST_PCT, 32'h0096_0000, 32'hffff_0000);
    wr(fpot_pkg::REG_TEST_CMD, 32'h0000_0400);
    batch_clr();
    cyc(2);
    chk("current force stopped", 32'h0000_0000, {30'h0, pins.cur_force});
    $display("test current forcing done");
    wr(fpot_pkg::REG_DO_CFG, 32'h0000_0820);
    cyc(4);
    chk("digital levels", 32'h0000_000d, {28'h0, pins.do_lvl});
    wr(fpot_pkg::REG_TMO, 32'h0000_0000);
    rd(fpot_pkg::REG_TMO, 32'h0000_0001, 32'h0000_001f);
    wr(fpot_pkg::REG_TMO, 32'h0000_001f);
    rd(fpot_pkg::REG_TMO, 32'h0000_001e, 32'h0000_001f);
    wr(fpot_pkg::REG_TMO, 32'h0000_0001);
    wr(fpot_pkg::REG_TEST_CMD, 32'h0000_0020);
    cyc(2);
    chk("digital test levels", 32'h0000_0009, {28'h0, pins.do_lvl});
    cyc(4000);
    wr(fpot_pkg::REG_TEST_CMD, 32'h0020_0000);
    cyc(4000);
    rd(fpot_pkg::REG_TEST_CMD, 32'h0000_0020, 32'h0000_0020);
    cyc(3000);
    rd(fpot_pkg::REG_TEST_CMD, 32'h0000_0000, 32'h0000_0020);
    chk("digital levels after expiry", 32'h0000_000d, {28'h0, pins.do_lvl});
    $display("test timeout done");
    cyc(2);
    wrap_up();
  end
endmodule
`default_nettype wire
